/* File: odsleep_ctrl.sv */
// Over-discharge protection and sleep controller with an AHB-Lite register slave.
// Assumes comparator levels arrive from the analog front end asynchronously.
//
// How it works
// - Cell under threshold past the delay turns discharge drive off, then sleeps if supply is below the wake threshold.
// - Detection timer starts on under-voltage; fault only if still low at timeout.
// - Fault also turns the charge drive off; both drives high.
// - Under-voltage threshold select is a two-bit configuration field.
// - Discharge resumes only after wake (if asleep), charge on, release time, discharge on.
// - Sleep entered by fault or by the sleep bit of the control word.
// - Asleep: both drives off, regulator off, FET control bits ignored.
// - No register access is accepted while asleep.
// - Supply at wake threshold ends sleep, restores regulator and bus.
// - After wake with check on, FET writes need every cell above threshold.
// - After wake, any cell below charge-enable threshold with check on holds both drives off until every cell rises above it.
// - Charge-enable threshold select is a two-bit configuration field.
// - Setting the check-disable bit switches the charge-enable check off.
// - No sleep entry while supply is at or above the wake threshold.
// - After recovery charge drive stays high until charge bit written one.
// - After recovery discharge drive stays high until discharge bit written one.
// - After wake an internal reset runs; FET control writes ignored meanwhile.
`default_nettype none

module odsleep_ctrl #(
   parameter int          NCELL            = 4,
   parameter int unsigned UV_DETECT_CYCLES = odsleep_pkg::UV_DETECT_CYC,
   parameter int unsigned RELEASE_CYCLES   = odsleep_pkg::UV_RELEASE_CYC,
   parameter int unsigned WAKE_RST_CYCLES  = odsleep_pkg::WAKE_RST_CYC
) (
   // Clock and reset
   input  wire logic             REF_CLK,
   input  wire logic             RST,
   // AHB-Lite slave
   input  wire logic             HSEL,
   input  wire logic [31:0]      HADDR,
   input  wire logic [1:0]       HTRANS,
   input  wire logic             HWRITE,
   input  wire logic [2:0]       HSIZE,
   input  wire logic [31:0]      HWDATA,
   input  wire logic             HREADY,
   output logic      [31:0]      HRDATA,
   output logic                  HREADYOUT,
   output logic                  HRESP,
   // Comparator and supply levels
   input  wire logic [NCELL-1:0] CELL_UNDER_UV,
   input  wire logic [NCELL-1:0] CELL_OVER_UVR,
   input  wire logic [NCELL-1:0] CELL_OVER_CE,
   input  wire logic             VCC_AT_WAKE,
   // Threshold selects to the analog front end
   output logic                  UNDERVOLT_SEL_HI,
   output logic                  UNDERVOLT_SEL_LO,
   output logic      [1:0]       CHARGE_ENABLE_THRESH_SEL,
   // FET drives, high turns the FET off
   output logic                  DISCHARGE_FET_DRIVE,
   output logic                  CHARGE_FET_DRIVE,
   // Regulator enable and interrupt
   output logic                  REGULATED_OUTPUT,
   output logic                  IRQ
);

   import odsleep_pkg::*;

   logic [NCELL-1:0] uv_s, uvr_s, ce_s;
   logic             vcc_wake;
   logic             any_uv, all_uvr, all_ce;

   odsleep_sync #(.W(3 * NCELL + 1)) u_sync (
      .clk (REF_CLK),
      .rst (RST),
      .d   ({CELL_UNDER_UV, CELL_OVER_UVR, CELL_OVER_CE, VCC_AT_WAKE}),
      .q   ({uv_s, uvr_s, ce_s, vcc_wake})
   );

   assign any_uv  = |uv_s;
   assign all_uvr = &uvr_s;
   assign all_ce  = &ce_s;

   // State
   state_t           state_reg, state_next;
   cfg_t             cfg_reg, cfg_next;
   ctrl_t            ctrl_reg, ctrl_next;
   logic             od_reg, od_next;
   logic             released_reg, released_next;
   logic             ce_chk_reg, ce_chk_next;
   logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
   logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
   logic             dis_drv_reg, dis_drv_next;
   logic             chg_drv_reg, chg_drv_next;
   logic             rgo_reg, rgo_next;
   logic             irq_reg, irq_next;

   // Bus
   logic             ap_valid_reg, ap_valid_next;
   logic             ap_write_reg, ap_write_next;
   logic [7:0]       ap_addr_reg, ap_addr_next;
   logic [31:0]      hrdata_reg, hrdata_next;
   logic             hreadyout_reg;

   logic             awake, ap_take, wr_ok;
   logic             cfg_wr, ctrl_wr, mask_wr, stat_rd;
   logic             sleep_req, ce_ok, ce_block, force_off;
   logic [IRQ_W-1:0] ev;
   logic             det_run, det_done, rel_run, rel_done, wrst_run, wrst_done;

   // Timers
   assign det_run  = (state_reg == ST_NORMAL) && any_uv;
   assign rel_run  = (state_reg == ST_RECOVER) && od_reg && ctrl_reg.charge_fet_ctrl_bit
                     && all_uvr && !ce_block;
   assign wrst_run = (state_reg == ST_WAKE_RST);

   odsleep_timer #(.W(32)) u_detect (
      .clk   (REF_CLK),
      .rst   (RST),
      .run   (det_run),
      .limit (32'(UV_DETECT_CYCLES)),
      .done  (det_done)
   );

   odsleep_timer #(.W(32)) u_release (
      .clk   (REF_CLK),
      .rst   (RST),
      .run   (rel_run),
      .limit (32'(RELEASE_CYCLES)),
      .done  (rel_done)
   );

   odsleep_timer #(.W(32)) u_wake_rst (
      .clk   (REF_CLK),
      .rst   (RST),
      .run   (wrst_run),
      .limit (32'(WAKE_RST_CYCLES)),
      .done  (wrst_done)
   );

   // Bus decode; nothing is taken while asleep
   assign awake   = (state_reg != ST_ASLEEP);
   assign ap_take = HSEL && HTRANS[1] && HREADY && awake;
   assign wr_ok   = ap_valid_reg && ap_write_reg && awake;
   assign cfg_wr  = wr_ok && (ap_addr_reg == CFG_OFS);
   assign ctrl_wr = wr_ok && (ap_addr_reg == CTRL_OFS);
   assign mask_wr = wr_ok && (ap_addr_reg == IRQ_MASK_OFS);
   assign stat_rd = ap_take && !HWRITE && (HADDR[7:0] == IRQ_STAT_OFS);

   assign sleep_req = ctrl_wr && HWDATA[CTRL_SLEEP_BIT];
   assign ce_ok     = cfg_reg.charge_check_disable || all_ce;
   assign ce_block  = ce_chk_reg && !ce_ok;

   always_comb begin
      ap_valid_next = ap_take;
      ap_write_next = ap_take ? HWRITE : ap_write_reg;
      ap_addr_next  = ap_take ? HADDR[7:0] : ap_addr_reg;
      hrdata_next   = 32'h0;
      if (ap_take && !HWRITE) begin
         unique case (HADDR[7:0])
            CFG_OFS:      hrdata_next = {27'h0, cfg_next};
            CTRL_OFS:     hrdata_next = {30'h0, ctrl_next};
            STAT_OFS:     hrdata_next = {25'h0, vcc_wake, ce_block, released_reg,
                                         od_reg, rgo_reg, state_reg};
            IRQ_STAT_OFS: hrdata_next = {28'h0, irq_stat_reg};
            IRQ_MASK_OFS: hrdata_next = {28'h0, irq_mask_next};
            default:      hrdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ap_valid_reg  <= 1'b0;
         ap_write_reg  <= 1'b0;
         ap_addr_reg   <= 8'h00;
         hrdata_reg    <= 32'h0;
         hreadyout_reg <= 1'b0;
      end else begin
         ap_valid_reg  <= ap_valid_next;
         ap_write_reg  <= ap_write_next;
         ap_addr_reg   <= ap_addr_next;
         hrdata_reg    <= hrdata_next;
         hreadyout_reg <= 1'b1;
      end
   end

   // Protection, sleep and recovery sequencing
   always_comb begin
      state_next    = state_reg;
      cfg_next      = cfg_reg;
      ctrl_next     = ctrl_reg;
      od_next       = od_reg;
      released_next = released_reg;
      ce_chk_next   = ce_chk_reg;
      irq_mask_next = irq_mask_reg;
      ev            = '0;
      if (cfg_wr) begin
         cfg_next = cfg_t'(HWDATA[4:0]);
      end
      if (mask_wr) begin
         irq_mask_next = HWDATA[IRQ_W-1:0];
      end
      if (ctrl_wr && !wrst_run && !ce_block) begin
         ctrl_next.discharge_fet_ctrl_bit = HWDATA[CTRL_DIS_BIT];
         ctrl_next.charge_fet_ctrl_bit    = HWDATA[CTRL_CHG_BIT];
      end
      if (ce_chk_reg && ce_ok && state_reg != ST_WAKE_RST) begin
         ce_chk_next = 1'b0;
      end
      unique case (state_reg)
         ST_NORMAL: begin
            if (det_done && any_uv) begin
               od_next            = 1'b1;
               ctrl_next          = '0;
               ev[IRQ_FAULT_BIT]  = 1'b1;
               if (!vcc_wake) begin
                  state_next        = ST_ASLEEP;
                  ev[IRQ_SLEEP_BIT] = 1'b1;
               end else begin
                  state_next = ST_RECOVER;
               end
            end else if (sleep_req && !vcc_wake) begin
               state_next        = ST_ASLEEP;
               ev[IRQ_SLEEP_BIT] = 1'b1;
            end
         end
         ST_ASLEEP: begin
            ctrl_next = '0;
            if (vcc_wake) begin
               state_next       = ST_WAKE_RST;
               ce_chk_next      = 1'b1;
               released_next    = 1'b0;
               ev[IRQ_WAKE_BIT] = 1'b1;
            end
         end
         ST_WAKE_RST: begin
            if (wrst_done) begin
               state_next = od_reg ? ST_RECOVER : ST_NORMAL;
            end
         end
         ST_RECOVER: begin
            if (rel_done && !released_reg) begin
               released_next       = 1'b1;
               ev[IRQ_RELEASE_BIT] = 1'b1;
            end
            if (sleep_req && !vcc_wake) begin
               state_next        = ST_ASLEEP;
               ev[IRQ_SLEEP_BIT] = 1'b1;
            end else if (released_reg && ctrl_next.discharge_fet_ctrl_bit) begin
               state_next    = ST_NORMAL;
               od_next       = 1'b0;
               released_next = 1'b0;
            end
         end
      endcase
      // Read clears the sticky bits, a new event wins
      irq_stat_next = (irq_stat_reg & ~{IRQ_W{stat_rd}}) | ev;
      irq_next      = |(irq_stat_next & irq_mask_next);
      force_off     = (state_next == ST_ASLEEP) || ce_block;
      // An early discharge write waits until recovery completes
      dis_drv_next  = force_off || !ctrl_next.discharge_fet_ctrl_bit
                      || od_next;
      chg_drv_next  = force_off || !ctrl_next.charge_fet_ctrl_bit;
      rgo_next      = (state_next != ST_ASLEEP);
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state_reg    <= ST_NORMAL;
         cfg_reg      <= CFG_RST;
         ctrl_reg     <= CTRL_RST;
         od_reg       <= 1'b0;
         released_reg <= 1'b0;
         ce_chk_reg   <= 1'b0;
         irq_stat_reg <= '0;
         irq_mask_reg <= MASK_RST;
         dis_drv_reg  <= 1'b0;
         chg_drv_reg  <= 1'b0;
         rgo_reg      <= 1'b1;
         irq_reg      <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cfg_reg      <= cfg_next;
         ctrl_reg     <= ctrl_next;
         od_reg       <= od_next;
         released_reg <= released_next;
         ce_chk_reg   <= ce_chk_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         dis_drv_reg  <= dis_drv_next;
         chg_drv_reg  <= chg_drv_next;
         rgo_reg      <= rgo_next;
         irq_reg      <= irq_next;
      end
   end

   assign HRDATA                   = hrdata_reg;
   assign HREADYOUT                = hreadyout_reg;
   assign HRESP                    = 1'b0;
   assign UNDERVOLT_SEL_HI         = cfg_reg.undervolt_sel[1];
   assign UNDERVOLT_SEL_LO         = cfg_reg.undervolt_sel[0];
   assign CHARGE_ENABLE_THRESH_SEL = cfg_reg.charge_enable_thresh_sel;
   assign DISCHARGE_FET_DRIVE      = dis_drv_reg;
   assign CHARGE_FET_DRIVE         = chg_drv_reg;
   assign REGULATED_OUTPUT         = rgo_reg;
   assign IRQ                      = irq_reg;

   // Checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   fault_drives_a: assert property (
      state_reg == ST_NORMAL && det_done && any_uv |=> DISCHARGE_FET_DRIVE && CHARGE_FET_DRIVE && od_reg)
      else $error("fault did not turn both drives off");

   fault_sleep_a: assert property (
      state_reg == ST_NORMAL && det_done && any_uv && !vcc_wake |=> state_reg == ST_ASLEEP)
      else $error("fault did not enter sleep");

   detect_delay_a: assert property (
      $rose(od_reg) |-> $past(det_done) && $past(any_uv))
      else $error("fault declared without timeout");

   sleep_off_a: assert property (
      state_reg == ST_ASLEEP |-> DISCHARGE_FET_DRIVE && CHARGE_FET_DRIVE && !REGULATED_OUTPUT)
      else $error("drive or regulator on while asleep");

   sleep_bus_a: assert property (
      state_reg == ST_ASLEEP ##1 state_reg == ST_ASLEEP |-> $stable(cfg_reg) && HRDATA == 32'h0)
      else $error("register access while asleep");

   wake_up_a: assert property (
      state_reg == ST_ASLEEP && vcc_wake |=> state_reg == ST_WAKE_RST && REGULATED_OUTPUT)
      else $error("wake did not restore regulator");

   no_sleep_a: assert property (
      state_reg != ST_ASLEEP && vcc_wake |=> state_reg != ST_ASLEEP)
      else $error("sleep entered above wake threshold");

   ce_hold_a: assert property (
      ce_block |=> DISCHARGE_FET_DRIVE && CHARGE_FET_DRIVE)
      else $error("drive on while charge check blocks");

   cfg_sel_a: assert property (
      cfg_wr |=> {CHARGE_ENABLE_THRESH_SEL, UNDERVOLT_SEL_HI, UNDERVOLT_SEL_LO} == $past(HWDATA[3:0]))
      else $error("threshold select not taken");

   chg_on_a: assert property (
      $fell(CHARGE_FET_DRIVE) |-> ctrl_reg.charge_fet_ctrl_bit)
      else $error("charge drive low without control bit");

   dis_on_a: assert property (
      $fell(DISCHARGE_FET_DRIVE) |-> ctrl_reg.discharge_fet_ctrl_bit && !od_reg)
      else $error("discharge drive low before recovery");

   wake_hold_a: assert property (
      state_reg == ST_WAKE_RST && ctrl_wr |=> $stable(ctrl_reg))
      else $error("FET control changed during wake reset");

endmodule : odsleep_ctrl

`default_nettype wire

/* File: odsleep_pkg.sv */
// Package for the over-discharge and sleep controller: register map,
// field layouts, reset values, state codes and timing counts.
// Assumes a 50 MHz reference clock.
`default_nettype none

package odsleep_pkg;

   // Clock rate and times in their own units
   localparam int CLK_KHZ       = 50000;
   localparam int UV_DETECT_MS  = 1000;
   localparam int UV_RELEASE_MS = 7;
   localparam int OV_DETECT_MS  = 1000;
   localparam int WAKE_EXTRA_MS = 200;

   // Derived cycle counts
   localparam int UV_DETECT_CYC  = UV_DETECT_MS * CLK_KHZ;
   localparam int UV_RELEASE_CYC = UV_RELEASE_MS * CLK_KHZ;
   localparam int WAKE_RST_CYC   =
      ((UV_DETECT_MS > OV_DETECT_MS ? UV_DETECT_MS : OV_DETECT_MS) + WAKE_EXTRA_MS) * CLK_KHZ;

   // Register byte offsets
   localparam logic [7:0] CFG_OFS      = 8'h00;
   localparam logic [7:0] CTRL_OFS     = 8'h04;
   localparam logic [7:0] STAT_OFS     = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

   // Control word bit positions
   localparam int CTRL_DIS_BIT   = 0;
   localparam int CTRL_CHG_BIT   = 1;
   localparam int CTRL_SLEEP_BIT = 2;

   // Interrupt status bit positions
   localparam int IRQ_FAULT_BIT   = 0;
   localparam int IRQ_SLEEP_BIT   = 1;
   localparam int IRQ_WAKE_BIT    = 2;
   localparam int IRQ_RELEASE_BIT = 3;
   localparam int IRQ_W           = 4;

   typedef struct packed {
      logic       charge_check_disable;
      logic [1:0] charge_enable_thresh_sel;
      logic [1:0] undervolt_sel;
   } cfg_t;

   typedef struct packed {
      logic charge_fet_ctrl_bit;
      logic discharge_fet_ctrl_bit;
   } ctrl_t;

   localparam cfg_t             CFG_RST  = 5'h00;
   localparam ctrl_t            CTRL_RST = 2'h3;
   localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

   // Gray codes along normal, asleep, wake reset, recovery
   typedef enum logic [1:0] {
      ST_NORMAL   = 2'h0,
      ST_ASLEEP   = 2'h1,
      ST_WAKE_RST = 2'h3,
      ST_RECOVER  = 2'h2
   } state_t;

endpackage : odsleep_pkg

`default_nettype wire

/* File: odsleep_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the inputs are quasi-static compared with the clock.
`default_nettype none

module odsleep_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : odsleep_sync

`default_nettype wire

/* File: odsleep_timer.sv */
// Delay timer: counts while run is high, done once the count reaches limit.
// Assumes run drops to restart the count.
`default_nettype none

module odsleep_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Control
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output logic              done
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   assign done = run && (cnt_reg == limit);

   always_comb begin
      if (!run) begin
         cnt_next = '0;
      end else if (done) begin
         cnt_next = cnt_reg;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

endmodule : odsleep_timer

`default_nettype wire

/* File: cell_pack_model.sv */
// Battery pack model: per-cell voltages in tenths of a volt, compared with the selected thresholds.
// Assumes the bench sets the cell voltages; the threshold tables are plain defaults.
`default_nettype none

module cell_pack_model #(
   parameter int              NCELL  = 4,
   parameter logic [7:0]      UVR_DV = 8'h1e,
   parameter logic [3:0][7:0] UV_DV  = {8'h1a, 8'h19, 8'h18, 8'h17},
   parameter logic [3:0][7:0] CE_DV  = {8'h10, 8'h0e, 8'h0c, 8'h0a}
) (
   // Cell voltages
   input  wire logic [NCELL*8-1:0] cell_dv,
   // Threshold selects
   input  wire logic [1:0]         uv_sel,
   input  wire logic [1:0]         ce_sel,
   // Comparator levels
   output logic      [NCELL-1:0]   under_uv,
   output logic      [NCELL-1:0]   over_uvr,
   output logic      [NCELL-1:0]   over_ce
);
   timeunit 1ns;
   timeprecision 1ps;

   always_comb begin
      for (int i = 0; i < NCELL; i++) begin
         under_uv[i] = cell_dv[i*8 +: 8] < UV_DV[uv_sel];
         over_uvr[i] = cell_dv[i*8 +: 8] > UVR_DV;
         over_ce[i]  = cell_dv[i*8 +: 8] > CE_DV[ce_sel];
      end
   end
endmodule : cell_pack_model

`default_nettype wire

/* File: battery_overdischarge_sleep_control_test.sv */
// Bench for the over-discharge and sleep controller: AHB-Lite register access, protection,
// sleep, wake and recovery. Assumes shortened counts and the cell pack model as far side.
`default_nettype none

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 100) begin @(posedge REF_CLK); k++; end if (!(c)) begin err_count++; finish_test(); end end

module battery_overdischarge_sleep_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import odsleep_pkg::*;

   localparam logic [31:0] ALL_OK = 32'h23232323;

   logic        REF_CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, VCC_AT_WAKE;
   logic [31:0] HADDR, HWDATA, HRDATA, cells, rd;
   logic [1:0]  HTRANS, ce_sel;
   logic [2:0]  HSIZE;
   logic        sel_hi, sel_lo, dis_drv, chg_drv, reg_on, irq;
   logic [3:0]  under_uv, over_uvr, over_ce;
   int          err_count, n_tests, k;

   odsleep_ctrl #(.NCELL(4), .UV_DETECT_CYCLES(20), .RELEASE_CYCLES(10), .WAKE_RST_CYCLES(30)) dut (
      .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .CELL_UNDER_UV(under_uv), .CELL_OVER_UVR(over_uvr), .CELL_OVER_CE(over_ce),
      .VCC_AT_WAKE(VCC_AT_WAKE), .UNDERVOLT_SEL_HI(sel_hi), .UNDERVOLT_SEL_LO(sel_lo),
      .CHARGE_ENABLE_THRESH_SEL(ce_sel), .DISCHARGE_FET_DRIVE(dis_drv), .CHARGE_FET_DRIVE(chg_drv),
      .REGULATED_OUTPUT(reg_on), .IRQ(irq));

   cell_pack_model #(.NCELL(4)) pack (
      .cell_dv(cells), .uv_sel({sel_hi, sel_lo}), .ce_sel(ce_sel),
      .under_uv(under_uv), .over_uvr(over_uvr), .over_ce(over_ce));

   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end

   task automatic finish_test();
      if (err_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Waits for an edge with the slave ready
   task automatic bus_phase();
      int n;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 50);
      if (HREADYOUT !== 1'b1) begin
         err_count++;
         finish_test();
      end
   endtask : bus_phase

   // One single transfer, then one idle edge so outputs settle
   task automatic bus_xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      HSEL   <= 1'b1;
      HADDR  <= {24'h0, a};
      HTRANS <= 2'h2;
      HWRITE <= wr_en;
      bus_phase();
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      bus_phase();
      rd = HRDATA;
      @(posedge REF_CLK);
   endtask : bus_xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_xfer(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus_xfer(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rd_chk

   initial begin
      RST = 1'b1;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0;
      VCC_AT_WAKE = 1'b0;
      cells = ALL_OK;
      err_count = 0;
      n_tests = 0;
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      `CHK({dis_drv, chg_drv, reg_on, irq, HRESP}, 5'h04)
      rd_chk(CFG_OFS, 32'h0);
      rd_chk(CTRL_OFS, 32'h3);
      rd_chk(STAT_OFS, 32'h4);
      rd_chk(IRQ_MASK_OFS, 32'h0);
      wr(8'h14, 32'hffffffff);
      rd_chk(8'h14, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(CFG_OFS, 32'(i + (3 - i) * 4));
         `CHK({sel_hi, sel_lo, ce_sel}, 4'(i * 4 + 3 - i))
         rd_chk(CFG_OFS, 32'(i + (3 - i) * 4));
      end
      wr(CFG_OFS, 32'h0);
      wr(IRQ_MASK_OFS, 32'hf);
      // Short dip below the under-voltage threshold
      cells <= 32'h23232314;
      repeat (12) @(posedge REF_CLK);
      cells <= ALL_OK;
      repeat (30) @(posedge REF_CLK);
      `CHK({dis_drv, chg_drv, irq}, 3'h0)
      cells <= 32'h23232314;
      `WAIT(dis_drv === 1'b1)
      `CHK({chg_drv, reg_on}, 2'h2)
      repeat (2) @(posedge REF_CLK);
      `CHK({reg_on, irq}, 2'h1)
      rd_chk(IRQ_STAT_OFS, 32'h0);
      wr(CTRL_OFS, 32'h3);
      `CHK({dis_drv, chg_drv, reg_on}, 3'h6)
      // Wake with one cell under the charge-enable threshold
      cells <= 32'h23230823;
      VCC_AT_WAKE <= 1'b1;
      `WAIT(reg_on === 1'b1)
      bus_xfer(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[1:0], 2'h3)
      wr(CTRL_OFS, 32'h3);
      `CHK({dis_drv, chg_drv}, 2'h3)
      rd_chk(IRQ_STAT_OFS, 32'h7);
      repeat (2) @(posedge REF_CLK);
      `CHK(irq, 1'b0)
      repeat (40) @(posedge REF_CLK);
      bus_xfer(1'b0, STAT_OFS, 32'h0);
      `CHK({rd[5], rd[3], rd[1:0]}, 4'he)
      wr(CTRL_OFS, 32'h2);
      `CHK({dis_drv, chg_drv}, 2'h3)
      wr(CFG_OFS, 32'h10);
      wr(CTRL_OFS, 32'h3);
      `CHK({dis_drv, chg_drv}, 2'h2)
      repeat (20) @(posedge REF_CLK);
      `CHK(dis_drv, 1'b1)
      cells <= ALL_OK;
      repeat (6) @(posedge REF_CLK);
      `CHK(dis_drv, 1'b1)
      `WAIT(dis_drv === 1'b0)
      rd_chk(IRQ_STAT_OFS, 32'h8);
      bus_xfer(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[1:0], 2'h0)
      // Sleep request while the supply is high, then low
      wr(CTRL_OFS, 32'h7);
      `CHK({reg_on, dis_drv, chg_drv}, 3'h4)
      VCC_AT_WAKE <= 1'b0;
      repeat (4) @(posedge REF_CLK);
      wr(CTRL_OFS, 32'h7);
      `WAIT(reg_on === 1'b0)
      `CHK({dis_drv, chg_drv}, 2'h3)
      VCC_AT_WAKE <= 1'b1;
      `WAIT(reg_on === 1'b1)
      repeat (40) @(posedge REF_CLK);
      `CHK(irq, 1'b1)
      wr(IRQ_MASK_OFS, 32'h0);
      repeat (2) @(posedge REF_CLK);
      `CHK(irq, 1'b0)
      wr(IRQ_MASK_OFS, 32'hf);
      repeat (2) @(posedge REF_CLK);
      `CHK(irq, 1'b1)
      rd_chk(IRQ_STAT_OFS, 32'h6);
      repeat (2) @(posedge REF_CLK);
      `CHK(irq, 1'b0)
      wr(CTRL_OFS, 32'h3);
      `CHK({dis_drv, chg_drv}, 2'h0)
      // Fault while the supply stays at the wake threshold
      cells <= 32'h23142323;
      `WAIT(dis_drv === 1'b1)
      repeat (2) @(posedge REF_CLK);
      `CHK({chg_drv, reg_on}, 2'h3)
      bus_xfer(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[1:0], 2'h2)
      finish_test();
   end
endmodule : battery_overdischarge_sleep_control_test

`default_nettype wire
